// ==== verilog/wrw_pkg.sv ====
// Package: constants, register map and state types of the windowed reset watchdog
package wrw_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    localparam int PRESCALE_CYCLES_DEF = 16384;
    localparam int PRE_W = 16;
    // Reset pin low time, plain default
    localparam int RST_OUT_NS = 20000;
    localparam int RST_OUT_CYCLES = (RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 16;

    // ****************************************
    // Register map, byte addresses
    // ****************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_MASK = 8'h08;
    localparam logic [7:0] ADR_OPT = 8'h0C;

    // ****************************************
    // Control register fields and values
    // ****************************************
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam int TMO_MSB = 5;
    localparam logic [6:0] CNT_RESET = 7'h7F;
    localparam logic [6:0] CNT_ROLL = 7'h40;

    // ****************************************
    // Event bits of status and mask
    // ****************************************
    localparam int EV_W = 3;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_SOFT = 1;
    localparam int EV_HALT = 2;

    typedef enum logic {WRW_RUN, WRW_RST_OUT} wrw_state_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wrw_wb_req_s;

    typedef struct packed {
        wrw_state_e state;
        logic [PRE_W-1:0] pre_cnt;
        logic [HOLD_W-1:0] hold_cnt;
        logic act;
        logic [6:0] cnt;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic [1:0] opt_meta;
        logic [1:0] opt_sync;
        logic halt_enter;
        logic ack;
        logic [7:0] dat;
    } wrw_state_s;

    localparam wrw_state_s ST_RESET = '{state: WRW_RUN, pre_cnt: 16'h0000, hold_cnt: 16'h0000, act: 1'b0,
        cnt: CNT_RESET, stat: 3'h0, mask: 3'h0, opt_meta: 2'h0, opt_sync: 2'h0, halt_enter: 1'b0,
        ack: 1'b0, dat: 8'h00};

endpackage

// ==== verilog/wrw_watchdog.sv ====
// Module: windowed reset watchdog with a Wishbone classic register slave
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

// Operation
// - Counter steps every 16384 oscillator cycles
// - Active and 40h to 3Fh starts reset
// - Counter runs even when not activated
// - Deactivated after reset; writes cannot deactivate
// - Activate set, top bit clear: reset
// - Halt while active gives reset
// - Low six bits set the timeout
// - Writes never clear the prescaler
// - Hardware option makes watchdog always active
module wrw_watchdog #(
    parameter int PRESCALE_CYCLES = wrw_pkg::PRESCALE_CYCLES_DEF
) (
    input wire logic clk_sys_i,                      // System clock, 50 MHz
    input wire logic rst_n_i,                        // Synchronous reset, active low
    input wire wrw_pkg::wrw_wb_req_s wb_req_i,       // Wishbone request group
    output logic wb_ack_o,                           // Wishbone acknowledge
    output logic [31:0] wb_dat_o,                    // Wishbone read data
    input wire logic hw_wdg_opt_i,                   // Option pin: hardware watchdog
    input wire logic reset_on_sleep_option_i,        // Option pin: reset on Halt
    input wire logic halt_req_i,                     // CPU Halt instruction, pulse
    output logic halt_enter_o,                       // Halt allowed, pulse
    output logic rst_pin_o,                          // Reset pin output level
    output logic rst_pin_oe_o,                       // Reset pin pulled low while high
    output logic irq_o                               // Interrupt, level
);

    localparam logic [wrw_pkg::PRE_W-1:0] PRE_MAX = wrw_pkg::PRE_W'(PRESCALE_CYCLES - 1);
    localparam logic [wrw_pkg::HOLD_W-1:0] HOLD_MAX = wrw_pkg::HOLD_W'(wrw_pkg::RST_OUT_CYCLES - 1);

    wrw_pkg::wrw_state_s st_ff;
    wrw_pkg::wrw_state_s nxt_st;
    logic tick;
    logic req_hit;
    logic commit;
    logic wr_ctrl;
    logic wr_mask;
    logic rd_stat;
    logic hw_on;
    logic sleep_opt;
    logic eff_act;
    logic fire;
    logic [wrw_pkg::EV_W-1:0] ev;

    // ****************************************
    // Register read multiplexer
    // ****************************************
    function automatic logic [7:0] rd_mux(input logic [7:0] adr, input wrw_pkg::wrw_state_s s);
        logic [7:0] r;
        r = 8'h00;
        unique case (adr)
            wrw_pkg::ADR_CTRL: r = {s.act, s.cnt};
            wrw_pkg::ADR_STAT: r = {5'h00, s.stat};
            wrw_pkg::ADR_MASK: r = {5'h00, s.mask};
            wrw_pkg::ADR_OPT: r = {5'h00, s.state == wrw_pkg::WRW_RST_OUT, s.opt_sync};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        ev = '0;
        fire = 1'b0;
        nxt_st.halt_enter = 1'b0;
        // Option pins through two flops
        nxt_st.opt_meta = {reset_on_sleep_option_i, hw_wdg_opt_i};
        nxt_st.opt_sync = st_ff.opt_meta;
        hw_on = st_ff.opt_sync[0];
        sleep_opt = st_ff.opt_sync[1];

        // Free-running prescaler, untouched by writes
        tick = (st_ff.pre_cnt == PRE_MAX);
        nxt_st.pre_cnt = tick ? '0 : st_ff.pre_cnt + 1'b1;

        // Bus: ack one cycle after request, commit at the ack edge
        req_hit = wb_req_i.cyc && wb_req_i.stb;
        nxt_st.ack = req_hit && !st_ff.ack;
        commit = req_hit && st_ff.ack;
        wr_ctrl = commit && wb_req_i.we && wb_req_i.sel[0] && (wb_req_i.adr == wrw_pkg::ADR_CTRL);
        wr_mask = commit && wb_req_i.we && wb_req_i.sel[0] && (wb_req_i.adr == wrw_pkg::ADR_MASK);
        rd_stat = commit && !wb_req_i.we && (wb_req_i.adr == wrw_pkg::ADR_STAT);
        if (req_hit && !st_ff.ack) begin
            nxt_st.dat = rd_mux(wb_req_i.adr, st_ff);
        end
        if (wr_mask) begin
            nxt_st.mask = wb_req_i.dat[wrw_pkg::EV_W-1:0];
        end

        eff_act = 1'b0;
        unique case (st_ff.state)
            wrw_pkg::WRW_RUN: begin
                if (wr_ctrl) begin
                    nxt_st.cnt = wb_req_i.dat[wrw_pkg::TOP_BIT:0];
                    nxt_st.act = st_ff.act | wb_req_i.dat[wrw_pkg::ACT_BIT];
                end else if (tick) begin
                    nxt_st.cnt = st_ff.cnt - 1'b1;
                end
                eff_act = nxt_st.act || hw_on;
                if (eff_act && !nxt_st.cnt[wrw_pkg::TOP_BIT] && (st_ff.cnt[wrw_pkg::TOP_BIT] || wr_ctrl)) begin
                    fire = 1'b1;
                    ev[wr_ctrl ? wrw_pkg::EV_SOFT : wrw_pkg::EV_TIMEOUT] = 1'b1;
                end else if (halt_req_i) begin
                    if (eff_act || sleep_opt) begin
                        fire = 1'b1;
                        ev[wrw_pkg::EV_HALT] = 1'b1;
                    end else begin
                        nxt_st.halt_enter = 1'b1;
                    end
                end
                if (fire) begin
                    nxt_st.state = wrw_pkg::WRW_RST_OUT;
                    nxt_st.hold_cnt = HOLD_MAX;
                end
            end
            wrw_pkg::WRW_RST_OUT: begin
                // Reset pin low; the device reset ends activation
                if (st_ff.hold_cnt == '0) begin
                    nxt_st.state = wrw_pkg::WRW_RUN;
                    nxt_st.act = 1'b0;
                    nxt_st.cnt = wrw_pkg::CNT_RESET;
                end else begin
                    nxt_st.hold_cnt = st_ff.hold_cnt - 1'b1;
                end
            end
        endcase

        // Sticky events; a new event wins over the read clear
        nxt_st.stat = (rd_stat ? '0 : st_ff.stat) | ev;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_ff <= wrw_pkg::ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = {24'h000000, st_ff.dat};
    assign halt_enter_o = st_ff.halt_enter;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = (st_ff.state == wrw_pkg::WRW_RST_OUT);
    assign irq_o = |(st_ff.stat & st_ff.mask);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_rst_begins;
        ##1 rst_pin_oe_o;
    endsequence

    sequence s_running;
        st_ff.state == wrw_pkg::WRW_RUN;
    endsequence

    cnt_hold_a: assert property (s_running and !tick && !wr_ctrl |=> $stable(st_ff.cnt))
        else $error("counter moved without a prescaler tick");

    cnt_step_a: assert property (s_running and tick && !wr_ctrl && !st_ff.act && !hw_on && !rst_pin_oe_o
        |=> st_ff.cnt == $past(st_ff.cnt) - 7'h01)
        else $error("counter did not step while inactive");

    roll_reset_a: assert property (s_running and st_ff.act && tick && !wr_ctrl
        && st_ff.cnt == wrw_pkg::CNT_ROLL |-> s_rst_begins)
        else $error("no reset on 40h to 3Fh roll");

    act_sticky_a: assert property (s_running and st_ff.act && !fire |=> st_ff.act)
        else $error("activation lost without reset");

    soft_reset_a: assert property (s_running and wr_ctrl && wb_req_i.dat[7] && !wb_req_i.dat[6]
        |-> s_rst_begins ##0 st_ff.stat[wrw_pkg::EV_SOFT])
        else $error("software reset request ignored");

    halt_reset_a: assert property (s_running and halt_req_i && (st_ff.act || hw_on)
        |-> s_rst_begins ##1 rst_pin_oe_o)
        else $error("halt while active gave no reset");

    tmo_load_a: assert property (s_running and wr_ctrl && wb_req_i.dat[6]
        |=> st_ff.cnt[5:0] == $past(wb_req_i.dat[5:0]) && st_ff.cnt[6])
        else $error("timeout field not loaded");

    pre_free_a: assert property (wr_ctrl && st_ff.pre_cnt != PRE_MAX
        |=> st_ff.pre_cnt == $past(st_ff.pre_cnt) + 1'b1)
        else $error("write disturbed the prescaler");

    hw_active_a: assert property (s_running and hw_on && !st_ff.act && tick && !wr_ctrl
        && st_ff.cnt == wrw_pkg::CNT_ROLL |-> s_rst_begins)
        else $error("hardware option did not force activation");

    ctrl_read_a: assert property (req_hit && !st_ff.ack && !wb_req_i.we && wb_req_i.adr == wrw_pkg::ADR_CTRL
        |=> wb_dat_o[7:0] == {$past(st_ff.act), $past(st_ff.cnt)})
        else $error("control read layout wrong");

    // ****************************************
    // Bus, prescaler, counter, activation, pulse, Halt, status and mask assertions
    // ****************************************
    sequence s_pulse_ends;
        ##1 !rst_pin_oe_o;
    endsequence

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    ack_answer_a: assert property (req_hit && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");

    ack_no_req_a: assert property (!req_hit |=> !wb_ack_o)
        else $error("ack without a request");

    pre_range_a: assert property (st_ff.pre_cnt <= PRE_MAX)
        else $error("prescaler beyond its period");

    pre_wrap_a: assert property (tick |=> st_ff.pre_cnt == '0)
        else $error("prescaler did not wrap after a tick");

    cnt_tick_a: assert property (s_running and tick && !wr_ctrl
        |=> st_ff.cnt == $past(st_ff.cnt) - 7'h01)
        else $error("counter missed a prescaler tick");

    idle_no_rst_a: assert property (s_running and !st_ff.act && !hw_on && !sleep_opt
        && !(wr_ctrl && wb_req_i.dat[wrw_pkg::ACT_BIT]) |=> !rst_pin_oe_o)
        else $error("reset while not activated");

    rst_deact_a: assert property ($rose(rst_n_i) |-> !st_ff.act && st_ff.cnt == wrw_pkg::CNT_RESET)
        else $error("activation survived reset");

    act_keep_a: assert property (s_running and wr_ctrl && st_ff.act
        && !wb_req_i.dat[wrw_pkg::ACT_BIT] |=> st_ff.act)
        else $error("write cleared activation");

    act_set_a: assert property (s_running and wr_ctrl && wb_req_i.dat[wrw_pkg::ACT_BIT]
        |=> st_ff.act)
        else $error("write did not activate");

    pulse_load_a: assert property ($rose(rst_pin_oe_o) |-> st_ff.hold_cnt == HOLD_MAX)
        else $error("reset pulse started with a wrong length");

    pulse_step_a: assert property (rst_pin_oe_o && st_ff.hold_cnt != '0
        |=> rst_pin_oe_o && st_ff.hold_cnt == $past(st_ff.hold_cnt) - 1'b1)
        else $error("reset pulse cut short");

    pulse_end_a: assert property (rst_pin_oe_o && st_ff.hold_cnt == '0
        |-> s_pulse_ends ##0 !st_ff.act && st_ff.cnt == wrw_pkg::CNT_RESET)
        else $error("pulse end did not restore the reset state");

    pulse_lock_a: assert property (rst_pin_oe_o && wr_ctrl && st_ff.hold_cnt != '0
        |=> $stable(st_ff.cnt) && $stable(st_ff.act))
        else $error("control write taken during the reset pulse");

    soft_hw_a: assert property (s_running and hw_on && wr_ctrl && !wb_req_i.dat[wrw_pkg::TOP_BIT]
        |-> s_rst_begins)
        else $error("hardware option ignored a software reset request");

    sleep_reset_a: assert property (s_running and halt_req_i && sleep_opt |-> s_rst_begins)
        else $error("halt with the sleep option gave no reset");

    halt_pass_a: assert property (s_running and halt_req_i && !eff_act && !sleep_opt
        |=> halt_enter_o && !rst_pin_oe_o)
        else $error("halt while inactive was blocked");

    halt_cause_a: assert property (halt_enter_o |-> $past(halt_req_i) && !rst_pin_oe_o)
        else $error("halt passed without a request");

    halt_in_pulse_a: assert property (rst_pin_oe_o && halt_req_i |=> !halt_enter_o)
        else $error("halt passed during the reset pulse");

    stat_keep_a: assert property (!rd_stat |=> (st_ff.stat & $past(st_ff.stat)) == $past(st_ff.stat))
        else $error("status bit lost without a read");

    stat_clear_a: assert property (rd_stat && ev == '0 |=> st_ff.stat == '0)
        else $error("status read did not clear");

    stat_set_wins_a: assert property (rd_stat && ev != '0 |=> st_ff.stat == $past(ev))
        else $error("event lost to the status read clear");

    fire_stat_a: assert property (fire |=> st_ff.stat != '0 && rst_pin_oe_o)
        else $error("reset pulse without a status event");

    stat_read_a: assert property (req_hit && !st_ff.ack && !wb_req_i.we && wb_req_i.adr == wrw_pkg::ADR_STAT
        |=> wb_dat_o[7:0] == {5'h00, $past(st_ff.stat)})
        else $error("status read data wrong");

    mask_write_a: assert property (wr_mask |=> st_ff.mask == $past(wb_req_i.dat[wrw_pkg::EV_W-1:0]))
        else $error("mask write not taken");

    lane_guard_a: assert property (commit && wb_req_i.we && !wb_req_i.sel[0] |=> $stable(st_ff.mask))
        else $error("write without byte lane 0 changed the mask");

endmodule

// ==== verification/wrw_watchdog_tb.sv ====
// Testbench: bus, timeout, software reset and Halt paths of the watchdog
`timescale 1ns/1ps

module wrw_watchdog_tb;
    // ****************************************
    // Clock, stimulus and design
    // ****************************************
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    wrw_pkg::wrw_wb_req_s wb = '0;
    logic hw_i = 1'b0;
    logic slp_i = 1'b0;
    logic halt_i = 1'b0;
    logic ack, hen, rpin, roe, irq;
    logic [31:0] rdat;
    logic [7:0] rd_v;
    logic [7:0] cnt_a;
    int errors = 0;
    int tests_run = 0;

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    wrw_watchdog #(.PRESCALE_CYCLES(8)) wrw_watchdog_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_req_i(wb), .wb_ack_o(ack), .wb_dat_o(rdat),
        .hw_wdg_opt_i(hw_i), .reset_on_sleep_option_i(slp_i), .halt_req_i(halt_i),
        .halt_enter_o(hen), .rst_pin_o(rpin), .rst_pin_oe_o(roe), .irq_o(irq));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h000000, d}};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            give_verdict();
        end
        rd_v = rdat[7:0];
        wb <= '0;
    endtask

    // Waits for the reset pulse, measures it, then checks status and irq
    task automatic pulse(input logic [2:0] ev, input int maxw, input logic ie);
        int n;
        n = 0;
        while (roe !== 1'b1 && n < 1100) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(n <= maxw, 1);
        n = 0;
        while (roe === 1'b1 && n < 1100) begin
            chk(rpin, 0);
            @(posedge clk_sys_i);
            n++;
        end
        chk(n, wrw_pkg::RST_OUT_CYCLES);
        chk(irq, ie);
        bus(1'b0, wrw_pkg::ADR_STAT, 8'h00);
        chk(rd_v, {5'h00, ev});
        cyc(1);
        chk(irq, 0);
        bus(1'b0, wrw_pkg::ADR_CTRL, 8'h00);
        chk(rd_v[7:6], 2'h1);
    endtask

    task automatic halt_case(input logic hw, input logic slp, input logic act, input logic rst);
        hw_i <= hw;
        slp_i <= slp;
        cyc(3);
        bus(1'b0, wrw_pkg::ADR_OPT, 8'h00);
        chk(rd_v[1:0], {slp, hw});
        if (act) begin
            bus(1'b1, wrw_pkg::ADR_CTRL, 8'hFF);
        end
        @(posedge clk_sys_i);
        halt_i <= 1'b1;
        @(posedge clk_sys_i);
        halt_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(hen, !rst);
        if (rst) begin
            pulse(3'h4, 0, 1'b1);
        end else begin
            chk(roe, 0);
        end
        hw_i <= 1'b0;
        slp_i <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        cyc(16);
        rst_n_i <= 1'b1;
        bus(1'b0, wrw_pkg::ADR_CTRL, 8'h00);
        chk(rd_v, 8'h7F);
        bus(1'b0, wrw_pkg::ADR_STAT, 8'h00);
        chk(rd_v, 8'h00);
        bus(1'b1, 8'h10, 8'hFF);
        bus(1'b0, 8'h10, 8'h00);
        chk(rd_v, 8'h00);
        bus(1'b1, wrw_pkg::ADR_MASK, 8'h07);
        bus(1'b0, wrw_pkg::ADR_MASK, 8'h00);
        chk(rd_v, 8'h07);
        // Captures 32 cycles apart: exactly four steps
        bus(1'b0, wrw_pkg::ADR_CTRL, 8'h00);
        cnt_a = rd_v;
        cyc(29);
        bus(1'b0, wrw_pkg::ADR_CTRL, 8'h00);
        chk(rd_v, cnt_a - 8'h04);
        // Timeout of one step: two ticks from 41h
        bus(1'b1, wrw_pkg::ADR_CTRL, 8'hC1);
        cyc(8);
        chk(roe, 0);
        pulse(3'h1, 12, 1'b1);
        // Activation sticks; a write of 7Fh with the activate bit clear keeps it
        bus(1'b1, wrw_pkg::ADR_CTRL, 8'hFF);
        bus(1'b1, wrw_pkg::ADR_CTRL, 8'h7F);
        bus(1'b0, wrw_pkg::ADR_CTRL, 8'h00);
        chk(rd_v[7], 1);
        // Mid-run reset clears activation
        rst_n_i <= 1'b0;
        cyc(2);
        rst_n_i <= 1'b1;
        bus(1'b0, wrw_pkg::ADR_CTRL, 8'h00);
        chk(rd_v, 8'h7F);
        bus(1'b1, wrw_pkg::ADR_MASK, 8'h00);
        bus(1'b1, wrw_pkg::ADR_CTRL, 8'h80);
        pulse(3'h2, 3, 1'b0);
        bus(1'b1, wrw_pkg::ADR_MASK, 8'h07);
        // Hardware option times out with the activate bit clear
        hw_i <= 1'b1;
        cyc(3);
        bus(1'b1, wrw_pkg::ADR_CTRL, 8'h41);
        pulse(3'h1, 20, 1'b1);
        halt_case(1'b0, 1'b0, 1'b0, 1'b0);
        halt_case(1'b0, 1'b0, 1'b1, 1'b1);
        halt_case(1'b1, 1'b0, 1'b0, 1'b1);
        halt_case(1'b0, 1'b1, 1'b0, 1'b1);
        give_verdict();
    end
endmodule
